// file: hw/irq_batch_read_monitors.sv
// Read-only batch monitors for interrupt factor vectors 21 to 40.
// Assumes request lines are levels synchronous to ref_clk.
//
// What this block does
// - Vector 21 shows external channels 8-31.
// - Unused upper monitor bits always read zero.
// - Bit reads one while source requests.
// - Register index plus sixteen gives vector.
// - Counter groups 2,1,0 at 19:14,13:8,7:2.
// - Counter group flag order fixed, high first.
// - Dual timer second bit1, first bit0.
// - Odd monitors: rx k+8 bit1, k bit0.
// - Even monitors: status/transmit k+8 then k.
// - DMA-routed serial channels 0-7 read zero.
// - Pulse generator channels on bits 8:0.
// - RTC request on bit 5 of vector 40.
// - Clock ready and watch requests bits 4:0.
`include "irq_monitor_regs.svh"
`default_nettype none

module irq_batch_read_monitors
    import irq_monitor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic avs_readdatavalid,
    output logic [1:0] avs_response,
    input wire irq_sources_s sources,
    input wire dma_route_s dma_route
);

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECODE_ERROR = 2'h3;

    // =================================================================
    // Word decode
    function automatic logic [31:0] monitor_word(input logic [4:0] index, input irq_sources_s src,
                                                input dma_route_s route);
        logic [31:0] word;
        logic [2:0] pair;
        logic [15:0] rx;
        logic [15:0] tx;
        logic [15:0] st;
        word = `MON_RESET_VALUE;
        pair = 3'h0;
        // DMA routing suppresses only the low eight channels
        rx = src.serial_rx_request & ~{8'h00, route.serial_rx_to_dma};
        tx = src.serial_tx_request & ~{8'h00, route.serial_tx_to_dma};
        st = src.serial_status_request & ~{8'h00, route.serial_tx_to_dma};
        case (index)
            5'(`MON_EXT_HI_INDEX):
            begin
                word[`EXT_HI_LSB +: `EXT_HI_WIDTH] = src.ext_pin_request_bits;
            end
            5'(`MON_QPC_TIMER_INDEX):
            begin
                word[`CNT2_LSB +: `CNT_GROUP_WIDTH] = src.counter2_request_bits;
                word[`CNT1_LSB +: `CNT_GROUP_WIDTH] = src.counter1_request_bits;
                word[`CNT0_LSB +: `CNT_GROUP_WIDTH] = src.counter0_request_bits;
                word[`TIMER_LSB + 1] = src.dual_timer_second_request;
                word[`TIMER_LSB] = src.dual_timer_first_request;
            end
            5'(`MON_PULSE_GEN_INDEX):
            begin
                word[`PULSE_GEN_WIDTH - 1:0] = src.pulse_gen_request_bits;
            end
            5'(`MON_CLOCK_RTC_INDEX):
            begin
                word[`RTC_BIT] = src.rtc_request_bit;
                word[4] = src.watch_counter_request;
                word[3] = src.usb_pll_ready_request;
                word[2] = src.main_pll_ready_request;
                word[1] = src.sub_osc_ready_request;
                word[0] = src.main_osc_ready_request;
            end
            default:
            begin
                if (index >= 5'(`MON_SERIAL_FIRST_INDEX) && index <= 5'(`MON_SERIAL_LAST_INDEX))
                begin
                    pair = 3'((index - 5'(`MON_SERIAL_FIRST_INDEX)) >> 1);
                    if (index[0])
                    begin
                        word[`SER_RX_HI_BIT] = rx[{1'b1, pair}];
                        word[`SER_RX_LO_BIT] = rx[{1'b0, pair}];
                    end
                    else
                    begin
                        word[`SER_ST_HI_BIT] = st[{1'b1, pair}];
                        word[`SER_TX_HI_BIT] = tx[{1'b1, pair}];
                        word[`SER_ST_LO_BIT] = st[{1'b0, pair}];
                        word[`SER_TX_LO_BIT] = tx[{1'b0, pair}];
                    end
                end
            end
        endcase
        return word;
    endfunction

    function automatic logic index_mapped(input logic [6:0] index);
        return index >= 7'(`MON_FIRST_INDEX) && index <= 7'(`MON_LAST_INDEX);
    endfunction

    // =================================================================
    // Avalon-MM slave: every access stalls one cycle, then answers
    mon_state_s cur;
    mon_state_s next_cur;

    always_comb
    begin
        next_cur = cur;
        next_cur.readdatavalid = 1'b0;
        case (cur.state)
            BUS_IDLE:
            begin
                next_cur.waitrequest = 1'b1;
                if (avs_read || avs_write)
                begin
                    next_cur.state = BUS_ANSWER;
                    next_cur.waitrequest = 1'b0;
                    next_cur.response = index_mapped(avs_address) ? RESP_OKAY : RESP_DECODE_ERROR;
                    // Sampled word is a snapshot; sources are never touched
                    if (avs_read && index_mapped(avs_address))
                    begin
                        next_cur.readdata = monitor_word(avs_address[4:0], sources, dma_route);
                    end
                    else
                    begin
                        next_cur.readdata = `MON_RESET_VALUE;
                    end
                    next_cur.readdatavalid = avs_read;
                end
            end
            BUS_ANSWER:
            begin
                next_cur.state = BUS_IDLE;
                next_cur.waitrequest = 1'b1;
            end
            default:
            begin
                next_cur.state = BUS_IDLE;
                next_cur.waitrequest = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk or posedge reset)
    begin
        if (reset)
        begin
            cur <= '{state: BUS_IDLE, waitrequest: 1'b1, readdatavalid: 1'b0,
                     readdata: `MON_RESET_VALUE, response: RESP_OKAY};
        end
        else
        begin
            cur <= next_cur;
        end
    end

    assign avs_readdata = cur.readdata;
    assign avs_waitrequest = cur.waitrequest;
    assign avs_readdatavalid = cur.readdatavalid;
    assign avs_response = cur.response;

    // Write data and byte enables are deliberately unused: all registers are read-only
    logic unused_inputs;
    assign unused_inputs = ^{avs_writedata, avs_byteenable};

endmodule

`default_nettype wire

// file: hw/irq_monitor_regs.svh
// Offsets, field positions and reset values of the interrupt monitor registers.
// Assumes inclusion from the package or the top module; definitions only.
`ifndef IRQ_MONITOR_REGS_SVH
`define IRQ_MONITOR_REGS_SVH

// =====================================================================
// Register indices (byte address is four times the index)
`define MON_FIRST_INDEX 5
`define MON_LAST_INDEX 24
`define MON_VECTOR_OFFSET 16
`define MON_EXT_HI_INDEX 5
`define MON_QPC_TIMER_INDEX 6
`define MON_SERIAL_FIRST_INDEX 7
`define MON_SERIAL_LAST_INDEX 22
`define MON_PULSE_GEN_INDEX 23
`define MON_CLOCK_RTC_INDEX 24

// =====================================================================
// Field positions
`define EXT_HI_LSB 0
`define EXT_HI_WIDTH 24
`define CNT0_LSB 2
`define CNT1_LSB 8
`define CNT2_LSB 14
`define CNT_GROUP_WIDTH 6
`define TIMER_LSB 0
`define SER_RX_LO_BIT 0
`define SER_RX_HI_BIT 1
`define SER_TX_LO_BIT 0
`define SER_ST_LO_BIT 1
`define SER_TX_HI_BIT 2
`define SER_ST_HI_BIT 3
`define PULSE_GEN_WIDTH 9
`define RTC_BIT 5

// =====================================================================
// Reset value
`define MON_RESET_VALUE 32'h00000000

`endif

// file: hw/irq_monitor_pkg.sv
// Types shared by the interrupt monitor block.
// Assumes the register header sits beside it on the include path.
`default_nettype none

package irq_monitor_pkg;
    // =================================================================
    // Request line groups
    typedef struct packed {
        logic [23:0] ext_pin_request_bits;
        logic [5:0] counter2_request_bits;
        logic [5:0] counter1_request_bits;
        logic [5:0] counter0_request_bits;
        logic dual_timer_second_request;
        logic dual_timer_first_request;
        logic [15:0] serial_rx_request;
        logic [15:0] serial_tx_request;
        logic [15:0] serial_status_request;
        logic [8:0] pulse_gen_request_bits;
        logic rtc_request_bit;
        logic watch_counter_request;
        logic usb_pll_ready_request;
        logic main_pll_ready_request;
        logic sub_osc_ready_request;
        logic main_osc_ready_request;
    } irq_sources_s;

    // =================================================================
    // Per-channel routing to DMA for serial channels 0-7
    typedef struct packed {
        logic [7:0] serial_rx_to_dma;
        logic [7:0] serial_tx_to_dma;
    } dma_route_s;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ANSWER = 2'b01
    } bus_state_e;

    typedef struct packed {
        bus_state_e state;
        logic waitrequest;
        logic readdatavalid;
        logic [31:0] readdata;
        logic [1:0] response;
    } mon_state_s;
endpackage

`default_nettype wire

// file: dv/irq_monitor_chk.sv
// Checker of bus timing and monitor word layouts.
// Assumes binding to the monitor top; sees its ports only.
`default_nettype none
module irq_monitor_chk
    import irq_monitor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [6:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic avs_readdatavalid,
    input wire logic [1:0] avs_response,
    input wire irq_sources_s sources
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Properties; slices follow the packed source struct, msb first
    wire logic take = avs_read && avs_waitrequest;
    default clocking dc @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    chk_answer_once: assert property (take |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("answer not one cycle");
    chk_read_valid: assert property (take |=> avs_readdatavalid)
        else $error("no readdatavalid");
    chk_write_quiet: assert property (avs_write && avs_waitrequest |=> !avs_readdatavalid)
        else $error("write gave read data");
    chk_ext_word: assert property (take && avs_address == 7'h05 |=>
        avs_readdata == {8'h00, $past(sources[106:83])})
        else $error("ext word wrong");
    chk_count_word: assert property (take && avs_address == 7'h06 |=>
        avs_readdata == {12'h000, $past(sources[82:63])})
        else $error("counter word wrong");
    chk_pulse_word: assert property (take && avs_address == 7'h17 |=>
        avs_readdata == {23'h0, $past(sources[14:6])})
        else $error("pulse word wrong");
    chk_clock_word: assert property (take && avs_address == 7'h18 |=>
        avs_readdata == {26'h0, $past(sources[5:0])})
        else $error("clock word wrong");
    chk_unmapped_err: assert property (take && avs_address > 7'h18 |=>
        avs_response == 2'h3 && avs_readdata == 32'h0)
        else $error("unmapped not refused");
    chk_serial_upper: assert property (take && avs_address >= 7'h07 && avs_address <= 7'h16 |=>
        avs_readdata[31:4] == 28'h0)
        else $error("serial upper bits set");
    chk_mapped_ok: assert property (take && avs_address >= 7'h05 && avs_address <= 7'h18 |=>
        avs_response == 2'h0)
        else $error("mapped read refused");
    cover property (take && avs_address == 7'h05);
    cover property (avs_write && avs_waitrequest);
    cover property (avs_response == 2'h3);
    cover property (take && avs_address >= 7'h07 && avs_address <= 7'h16);
endmodule
bind irq_batch_read_monitors irq_monitor_chk chk_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_readdatavalid(avs_readdatavalid), .avs_response(avs_response), .sources(sources));
`default_nettype wire

// file: dv/irq_source_model.sv
// Far side: peripheral request levels and DMA routing.
// Assumes the bench sets wanted levels; they land one edge later.
`default_nettype none
module irq_source_model
    import irq_monitor_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire irq_sources_s want_src,
    input wire dma_route_s want_route,
    output var irq_sources_s sources,
    output var dma_route_s dma_route
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========
    // Peripherals hold no request while reset
    always_ff @(posedge ref_clk or posedge reset)
        if (reset)
            {sources, dma_route} <= '0;
        else
            {sources, dma_route} <= {want_src, want_route};
endmodule
`default_nettype wire

// file: dv/tb.sv
// Bench: reads the monitors over Avalon-MM and compares words.
// Assumes the source model and checker compile first.
`default_nettype none
module tb
    import irq_monitor_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [6:0] avs_address = 7'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_readdata, d;
    logic avs_waitrequest, avs_readdatavalid;
    logic [1:0] avs_response;
    irq_sources_s want_src = '0, sources;
    dma_route_s want_route = '0, dma_route;
    int n_errors = 0, checks_done = 0, cyc = 0;
    always #2 ref_clk = ~ref_clk;
    irq_source_model src_u (.ref_clk(ref_clk), .reset(reset), .want_src(want_src), .want_route(want_route),
        .sources(sources), .dma_route(dma_route));
    irq_batch_read_monitors dut_u (.ref_clk(ref_clk), .reset(reset), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(32'hFFFFFFFF), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .avs_readdatavalid(avs_readdatavalid),
        .avs_response(avs_response), .sources(sources), .dma_route(dma_route));
    // ==========
    // Bus access and compare
    task automatic acc(input logic w, input logic [6:0] a);
        avs_address <= a;
        avs_read <= ~w;
        avs_write <= w;
        @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0)
            @(posedge ref_clk);
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks_done++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [31:0] exp, input string what);
        acc(1'b0, a);
        chk(d, exp, what);
    endtask
    task automatic close_out();
        if (n_errors == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, far above the run length
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_errors++;
            close_out();
        end
    end
    // ==========
    // Scenarios
    initial
    begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        want_src <= {24'hA55AC3, 6'h21, 6'h0C, 6'h3F, 2'b10, 16'hFFFF, 16'hFFFF, 16'h00FF, 9'h1A5, 6'h36};
        want_route <= {8'h55, 8'hAA};
        repeat (2) @(posedge ref_clk);
        rd(7'h05, 32'h00A55AC3, "ext");
        chk({30'h0, avs_response}, 32'h0, "ok response");
        rd(7'h06, {12'h000, 6'h21, 6'h0C, 6'h3F, 2'b10}, "counter");
        for (int k = 0; k < 8; k++)
        begin
            rd(7'(7 + 2 * k), {30'h0, 1'b1, ~want_route.serial_rx_to_dma[k]}, "rx");
            rd(7'(8 + 2 * k), {28'h0, 2'b01, {2{~want_route.serial_tx_to_dma[k]}}}, "tx");
        end
        rd(7'h17, 32'h000001A5, "pulse");
        rd(7'h18, 32'h00000036, "clock");
        acc(1'b1, 7'h05);
        rd(7'h05, 32'h00A55AC3, "after write");
        rd(7'h19, 32'h0, "unmapped");
        chk({30'h0, avs_response}, 32'h3, "response");
        rd(7'h04, 32'h0, "below map");
        chk({30'h0, avs_response}, 32'h3, "low response");
        want_src <= '0;
        repeat (2) @(posedge ref_clk);
        rd(7'h05, 32'h0, "dropped");
        close_out();
    end
endmodule
`default_nettype wire
